// [hw/slc_pkg.sv]
package slc_pkg;

    // Register offsets on the configuration page
    localparam logic [7:0] LANE0_DEEMPH_OFS   = 8'h32;
    localparam logic [7:0] LANE1_DEEMPH_OFS   = 8'h33;
    localparam logic [7:0] LANE2_DEEMPH_OFS   = 8'h34;
    localparam logic [7:0] LANE3_DEEMPH_OFS   = 8'h35;
    localparam logic [7:0] SYNC_SEL_OFS       = 8'h36;
    localparam logic [7:0] SER_MULT_OFS       = 8'h37;
    localparam logic [7:0] SE_SYNC_EN_OFS     = 8'h3c;
    localparam logic [7:0] SYSREF_MASK_OFS    = 8'h3e;

    // Field positions
    localparam int DEEMPH_LSB      = 2;
    localparam int DEEMPH_W        = 6;
    localparam int SYNC_SEL_BIT    = 6;
    localparam int MULT_W          = 2;
    localparam int SE_SYNC_ON_BIT  = 0;
    localparam int DIV_BLOCK_BIT   = 6;
    localparam int OSC_BLOCK_BIT   = 5;

    // Writable-bit masks; reserved bits read back as zero
    localparam logic [7:0] DEEMPH_MASK  = 8'hfc;
    localparam logic [7:0] SYNC_MASK    = 8'h40;
    localparam logic [7:0] MULT_MASK    = 8'h03;
    localparam logic [7:0] SE_MASK      = 8'h01;
    localparam logic [7:0] SYSREF_MASK  = 8'h60;

    // Reset value of every register
    localparam logic [7:0] REG_RESET    = 8'h00;

    // Multiplier codes
    typedef enum logic [1:0] {
        SLC_MULT_20X = 2'b00,
        SLC_MULT_16X = 2'b01,
        SLC_MULT_40X = 2'b10,
        SLC_MULT_80X = 2'b11
    } slc_mult_e;

    // De-emphasis codes with documented strengths
    localparam logic [5:0] DEEMPH_0DB   = 6'h00;
    localparam logic [5:0] DEEMPH_1DB   = 6'h01;
    localparam logic [5:0] DEEMPH_2DB   = 6'h03;
    localparam logic [5:0] DEEMPH_4DB   = 6'h07;
    localparam logic [5:0] DEEMPH_6DB   = 6'h0f;

    // Decoded PLL multiplication factor
    localparam logic [6:0] FACTOR_20    = 7'h14;
    localparam logic [6:0] FACTOR_16    = 7'h10;
    localparam logic [6:0] FACTOR_40    = 7'h28;
    localparam logic [6:0] FACTOR_80    = 7'h50;

endpackage

// [hw/slc_edge_sync.sv]
`timescale 1ns/10ps

// Two-flop synchroniser with rising-edge pulse taken from the second stage
module slc_edge_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic async_in,
    output logic      level_out,
    output logic      rise_out
);

    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
    } slc_sync_s;

    slc_sync_s st_q;
    slc_sync_s st_d;

    always_comb
    begin
        st_d      = st_q;
        st_d.meta = async_in;
        st_d.sync = st_q.meta;
        st_d.prev = st_q.sync;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // Edge detector looks only at the second and third stages
    assign level_out = st_q.sync;
    assign rise_out  = st_q.sync & ~st_q.prev;

endmodule

// [hw/slc_config_regs.sv]
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps

// Function
// - Per-lane six-bit de-emphasis field, bits 7:2
// - De-emphasis codes map to documented strengths
// - Sync select bit clear picks differential
// - Two-bit multiplier code picks PLL factor
// - Single-ended sync needs enable and select
// - Divider block bit masks SYSREF divider reset
// - Oscillator block bit masks phase/counter reset
module slc_config_regs (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       sync_diff_in,
    input  wire logic       sync_se_in,
    input  wire logic       sysref_in,
    output logic            sync_req,
    output logic            sync_se_active,
    output logic [23:0]     lane_deemph_sel,
    output logic [3:0]      lane_deemph_valid,
    output logic [1:0]      pll_mult_code,
    output logic [6:0]      pll_factor,
    output logic            divider_reset,
    output logic            osc_counter_reset
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [3:0][5:0] deemph;
        logic            se_sync_sel;
        logic [1:0]      mult;
        logic            se_sync_on;
        logic            div_block;
        logic            osc_block;
        logic [7:0]      rdata;
        logic            sync;
        logic            se_active;
        logic            div_rst;
        logic            osc_rst;
        logic [6:0]      factor;
        logic [3:0]      valid;
    } slc_regs_s;

    // Code 00 selects 20x, so the decoded factor must agree with it from
    // the first cycle after reset; valid starts all ones, every field but factor and valid at zero
    localparam slc_regs_s RST_ST = '{
        factor  : slc_pkg::FACTOR_20,
        valid   : 4'hf,
        default : '0
    };

    slc_regs_s st_q;
    slc_regs_s st_d;

    logic diff_lvl;
    logic se_lvl;
    logic sysref_rise;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    // Every pin passes two flops before any logic reads it

    slc_edge_sync u_sync_diff (
        .clk       (clk),
        .rst_n     (rst_n),
        .async_in  (sync_diff_in),
        .level_out (diff_lvl),
        .rise_out  ()
    );

    slc_edge_sync u_sync_se (
        .clk       (clk),
        .rst_n     (rst_n),
        .async_in  (sync_se_in),
        .level_out (se_lvl),
        .rise_out  ()
    );

    // Only the rising edge of the strobe matters, its level is not used
    slc_edge_sync u_sysref (
        .clk       (clk),
        .rst_n     (rst_n),
        .async_in  (sysref_in),
        .level_out (),
        .rise_out  (sysref_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [6:0] mult_factor(input logic [1:0] code);
        logic [6:0] f;
        f = slc_pkg::FACTOR_20;
        unique case (slc_pkg::slc_mult_e'(code))
            slc_pkg::SLC_MULT_20X: f = slc_pkg::FACTOR_20;
            slc_pkg::SLC_MULT_16X: f = slc_pkg::FACTOR_16;
            slc_pkg::SLC_MULT_40X: f = slc_pkg::FACTOR_40;
            slc_pkg::SLC_MULT_80X: f = slc_pkg::FACTOR_80;
        endcase
        return f;
    endfunction

    // Codes with a documented strength; the strongest step, code 0f, is
    // treated as known here like the other four
    function automatic logic deemph_known(input logic [5:0] code);
        return (code == slc_pkg::DEEMPH_0DB) || (code == slc_pkg::DEEMPH_1DB)
            || (code == slc_pkg::DEEMPH_2DB) || (code == slc_pkg::DEEMPH_4DB)
            || (code == slc_pkg::DEEMPH_6DB);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state
    // Writes land at the strobe edge; read data stands one cycle, then
    // returns to zero, so a stale value never looks like a fresh answer

    always_comb
    begin
        logic se_mode;
        se_mode = 1'b0;
        st_d    = st_q;

        // Reserved bits of a write are dropped, so they read back as zero
        if (reg_wr)
        begin
            unique case (reg_addr)
                slc_pkg::LANE0_DEEMPH_OFS:
                    st_d.deemph[0] = reg_wdata[7:2];
                slc_pkg::LANE1_DEEMPH_OFS:
                    st_d.deemph[1] = reg_wdata[7:2];
                slc_pkg::LANE2_DEEMPH_OFS:
                    st_d.deemph[2] = reg_wdata[7:2];
                slc_pkg::LANE3_DEEMPH_OFS:
                    st_d.deemph[3] = reg_wdata[7:2];
                slc_pkg::SYNC_SEL_OFS:
                    st_d.se_sync_sel = reg_wdata[slc_pkg::SYNC_SEL_BIT];
                slc_pkg::SER_MULT_OFS:
                    st_d.mult = reg_wdata[slc_pkg::MULT_W-1:0];
                slc_pkg::SE_SYNC_EN_OFS:
                    st_d.se_sync_on = reg_wdata[slc_pkg::SE_SYNC_ON_BIT];
                slc_pkg::SYSREF_MASK_OFS:
                begin
                    st_d.div_block = reg_wdata[slc_pkg::DIV_BLOCK_BIT];
                    st_d.osc_block = reg_wdata[slc_pkg::OSC_BLOCK_BIT];
                end
                default: ;
            endcase
        end

        // Unmapped reads return zero; reserved bits read as zero
        st_d.rdata = 8'h00;
        if (reg_rd)
        begin
            unique case (reg_addr)
                slc_pkg::LANE0_DEEMPH_OFS: st_d.rdata = {st_q.deemph[0], 2'b00};
                slc_pkg::LANE1_DEEMPH_OFS: st_d.rdata = {st_q.deemph[1], 2'b00};
                slc_pkg::LANE2_DEEMPH_OFS: st_d.rdata = {st_q.deemph[2], 2'b00};
                slc_pkg::LANE3_DEEMPH_OFS: st_d.rdata = {st_q.deemph[3], 2'b00};
                slc_pkg::SYNC_SEL_OFS:
                    st_d.rdata = {1'b0, st_q.se_sync_sel, 6'h00};
                slc_pkg::SER_MULT_OFS:
                    st_d.rdata = {6'h00, st_q.mult};
                slc_pkg::SE_SYNC_EN_OFS:
                    st_d.rdata = {7'h00, st_q.se_sync_on};
                slc_pkg::SYSREF_MASK_OFS:
                    st_d.rdata = {1'b0, st_q.div_block, st_q.osc_block, 5'h00};
                default: st_d.rdata = 8'h00;
            endcase
        end

        // Single-ended only when both bits are set, else differential
        se_mode        = st_q.se_sync_on & st_q.se_sync_sel;
        st_d.se_active = se_mode;
        st_d.sync      = se_mode ? se_lvl : diff_lvl;

        st_d.div_rst = sysref_rise & ~st_q.div_block;
        st_d.osc_rst = sysref_rise & ~st_q.osc_block;

        // Factor follows the code only; no other register field affects it
        st_d.factor = mult_factor(st_q.mult);

        // Validity is registered beside the codes so both change together
        for (int i = 0; i < 4; i++)
        begin
            st_d.valid[i] = deemph_known(st_d.deemph[i]);
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_q <= RST_ST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    // All outputs come straight from flops; no decode sits after them

    assign reg_rdata         = st_q.rdata;
    assign sync_req          = st_q.sync;
    assign sync_se_active    = st_q.se_active;
    assign lane_deemph_sel   = st_q.deemph;
    assign pll_mult_code     = st_q.mult;
    assign pll_factor        = st_q.factor;
    assign divider_reset     = st_q.div_rst;
    assign osc_counter_reset = st_q.osc_rst;
    assign lane_deemph_valid = st_q.valid;

endmodule

// [bench/slc_far_model.sv]
`timescale 1ns/10ps
// Receiver side: sync request levels and SYSREF pulses on command
module slc_far_model (
    input  wire logic clk,
    output logic      sync_diff,
    output logic      sync_se,
    output logic      sysref
);
    initial
    begin
        sync_diff = 1'b0;
        sync_se   = 1'b0;
        sysref    = 1'b0;
    end
    task automatic drive(input logic d, input logic s);
        @(posedge clk);
        sync_diff <= d;
        sync_se   <= s;
    endtask
    // Held high three cycles, then driven low; the task returns without waiting
    task automatic sysref_pulse();
        @(posedge clk);
        sysref <= 1'b1;
        repeat (3) @(posedge clk);
        sysref <= 1'b0;
    endtask
endmodule

// [bench/slc_config_regs_properties.sv]
`timescale 1ns/10ps
module slc_config_regs_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        sync_diff_in,
    input wire logic        sync_se_in,
    input wire logic        sysref_in,
    input wire logic        sync_req,
    input wire logic        sync_se_active,
    input wire logic [23:0] lane_deemph_sel,
    input wire logic [3:0]  lane_deemph_valid,
    input wire logic [1:0]  pll_mult_code,
    input wire logic [6:0]  pll_factor,
    input wire logic        divider_reset,
    input wire logic        osc_counter_reset
);
    logic div_blk_q;
    logic osc_blk_q;
    // Mask bits mirrored from observed writes; no read port needed
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_blk_q <= 1'b0;
            osc_blk_q <= 1'b0;
        end
        else if (reg_wr && reg_addr == slc_pkg::SYSREF_MASK_OFS)
        begin
            div_blk_q <= reg_wdata[slc_pkg::DIV_BLOCK_BIT];
            osc_blk_q <= reg_wdata[slc_pkg::OSC_BLOCK_BIT];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence sysref_seen;
        $rose(sysref_in) ##3 1'b1;
    endsequence
    a_lane_write: assert property (
        reg_wr && reg_addr == slc_pkg::LANE0_DEEMPH_OFS
        |=> lane_deemph_sel[5:0] == $past(reg_wdata[7:2]))
        else $error("lane code not stored");
    a_code_valid: assert property (lane_deemph_valid[2] ==
        (lane_deemph_sel[17:12] inside {6'h00, 6'h01, 6'h03, 6'h07, 6'h0f}))
        else $error("lane code validity wrong");
    a_diff_follow: assert property (
        (!sync_se_active)[*4] |-> sync_req == $past(sync_diff_in, 3))
        else $error("sync not from differential input");
    a_se_follow: assert property (
        sync_se_active[*4] |-> sync_req == $past(sync_se_in, 3))
        else $error("sync not from single-ended input");
    a_mult_factor: assert property (pll_factor ==
        (($past(pll_mult_code) == slc_pkg::SLC_MULT_20X) ? 7'h14 :
         ($past(pll_mult_code) == slc_pkg::SLC_MULT_16X) ? 7'h10 :
         ($past(pll_mult_code) == slc_pkg::SLC_MULT_40X) ? 7'h28 : 7'h50))
        else $error("pll factor wrong");
    a_div_pulse: assert property (
        sysref_seen |-> divider_reset == !div_blk_q)
        else $error("divider reset pulse wrong");
    a_osc_pulse: assert property (
        sysref_seen |-> osc_counter_reset == !osc_blk_q)
        else $error("oscillator reset pulse wrong");
endmodule
////////////////////////////////////////////////////////////////////////////
bind slc_config_regs slc_config_regs_chk i_chk (.clk, .rst_n, .reg_addr,
    .reg_wdata, .reg_wr, .sync_diff_in, .sync_se_in, .sysref_in, .sync_req,
    .sync_se_active, .lane_deemph_sel, .lane_deemph_valid, .pll_mult_code,
    .pll_factor, .divider_reset, .osc_counter_reset);

// [bench/tb.sv]
`timescale 1ns/10ps
module tb;
    logic        clk, rst_n, reg_wr, reg_rd, sync_req, sync_se_active;
    logic        sync_diff_in, sync_se_in, sysref_in, rd_d;
    logic        divider_reset, osc_counter_reset;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, v[8], exp_q[$];
    logic [23:0] lane_deemph_sel;
    logic [3:0]  lane_deemph_valid;
    logic [1:0]  pll_mult_code;
    logic [6:0]  pll_factor;
    int          miscompares, checks, div_n, osc_n;
    logic [7:0]  ofs[8] = '{8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37,
                            8'h3c, 8'h3e};
    logic [7:0]  msk[8] = '{8'hfc, 8'hfc, 8'hfc, 8'hfc, 8'h40, 8'h03,
                            8'h01, 8'h60};
    logic [5:0]  codes[8] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0f, 6'h02,
                              6'h1f, 6'h3f};
    logic [6:0]  fac[4] = '{7'h14, 7'h10, 7'h28, 7'h50};
    slc_config_regs i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .sync_diff_in, .sync_se_in, .sysref_in,
        .sync_req, .sync_se_active, .lane_deemph_sel, .lane_deemph_valid,
        .pll_mult_code, .pll_factor, .divider_reset, .osc_counter_reset);
    slc_far_model i_far (.clk, .sync_diff(sync_diff_in),
        .sync_se(sync_se_in), .sysref(sysref_in));
    ////////////////////////////////////////////////////////////////////////
    task automatic cmp(string n, logic [23:0] e, logic [23:0] g);
        checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd   <= 1'b0;
    endtask
    task automatic settle(int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic complete_run();
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Read data stands one cycle only, so it is taken mid-cycle
    always @(posedge clk) rd_d <= reg_rd;
    always @(negedge clk)
    begin
        if (rd_d === 1'b1)
            cmp("rdata", 24'(exp_q.pop_front()), 24'(reg_rdata));
        div_n += int'(divider_reset === 1'b1);
        osc_n += int'(osc_counter_reset === 1'b1);
    end
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        complete_run();
    end
    initial
    begin
        void'($urandom(15835));
        rst_n     = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ofs[i]) rd(ofs[i], 8'h00);
        foreach (ofs[i])
        begin
            v[i] = 8'($urandom()) & msk[i];
            wr(ofs[i], v[i]);
            rd(ofs[i], v[i]);
        end
        wr(8'h40, 8'hff);
        rd(8'h40, 8'h00);
        settle(1);
        for (int i = 0; i < 4; i++)
            cmp("lane", 24'(v[i][7:2]), 24'(lane_deemph_sel[6*i+:6]));
        foreach (codes[i])
        begin
            wr(8'h34, {codes[i], 2'b00});
            settle(0);
            cmp("valid", 24'(i < 5), 24'(lane_deemph_valid[2]));
        end
        for (int m = 0; m < 4; m++)
        begin
            wr(8'h16, (m == 2) ? 8'h70 : 8'h00);
            wr(8'h37, 8'(m));
            settle(1);
            cmp("factor", 24'(fac[m]), 24'(pll_factor));
            cmp("mult", 24'(m), 24'(pll_mult_code));
        end
        wr(8'h3c, 8'h00);
        wr(8'h36, 8'h00);
        i_far.drive(1'b1, 1'b0);
        settle(4);
        cmp("sync", 24'h1, 24'(sync_req));
        i_far.drive(1'b0, 1'b1);
        settle(4);
        cmp("sync", 24'h0, 24'(sync_req));
        wr(8'h36, 8'h40);
        settle(4);
        cmp("se", 24'h0, 24'({sync_se_active, sync_req}));
        wr(8'h3c, 8'h01);
        settle(4);
        cmp("se", 24'h3, 24'({sync_se_active, sync_req}));
        i_far.drive(1'b1, 1'b0);
        settle(4);
        cmp("se", 24'h2, 24'({sync_se_active, sync_req}));
        for (int m = 0; m < 4; m++)
        begin
            wr(8'h3e, 8'(m << 5));
            div_n = 0;
            osc_n = 0;
            i_far.sysref_pulse();
            settle(6);
            cmp("div", 24'(m < 2), 24'(div_n));
            cmp("osc", 24'(m % 2 == 0), 24'(osc_n));
        end
        complete_run();
    end
endmodule
